// ===== common/autoneg_pkg.sv
// Constants, field layouts and carrier types for the auto-negotiation page registers.
// Assumes a 32-bit APB slave whose register index is the byte address divided by four.
package autoneg_pkg;
  localparam int ADDR_W = 8;
  localparam int IRQ_N = 3;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_PARTNER_ABILITY = 6'h05;
  localparam logic [5:0] IDX_EXPANSION = 6'h06;
  localparam logic [5:0] IDX_LOCAL_NP = 6'h07;
  localparam logic [5:0] IDX_PARTNER_NP = 6'h08;
  localparam logic [5:0] IDX_DIGITAL_MISC = 6'h10;
  localparam logic [5:0] IDX_FRONT_END_ONE = 6'h11;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h1b;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h1c;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h1d;

  // Reset values.
  localparam logic [15:0] RST_PARTNER_ABILITY = 16'h0001;
  localparam logic [15:0] RST_LOCAL_NP = 16'h2001;
  localparam logic [15:0] RST_PARTNER_NP = 16'h0000;
  localparam logic [15:0] RST_DIGITAL_MISC = 16'h0000;
  localparam logic [15:0] RST_FRONT_END_ONE = 16'h0000;
  localparam logic [IRQ_N-1:0] RST_IRQ_ENABLE = 3'h0;

  // Expansion register fields.
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_LP_NP_ABLE = 3;
  localparam int EXP_NP_ABLE = 2;
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_LP_AN_ABLE = 0;
  localparam logic LOCAL_NP_ABLE = 1'b1;

  // Local next page fields: next page, message page, ack2 and message are writable.
  localparam int NP_TOGGLE = 11;
  localparam logic [15:0] LOCAL_NP_WMASK = 16'hb7ff;
  localparam int DIG_PLL_OFF = 4;

  // Interrupt status bits.
  localparam int IRQ_PAGE_RX = 0;
  localparam int IRQ_PD_FAULT = 1;
  localparam int IRQ_LP_NP = 2;

  typedef struct packed {
    logic next_page;
    logic ack;
    logic remote_fault;
    logic reserved;
    logic [1:0] pause;
    logic t4;
    logic fd100;
    logic hd100;
    logic fd10;
    logic hd10;
    logic [4:0] selector;
  } base_word_s;

  typedef struct packed {
    logic next_page;
    logic ack;
    logic msg_page;
    logic ack2;
    logic toggle;
    logic [10:0] message;
  } np_word_s;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_WAIT = 3'b010,
    PH_DONE = 3'b100
  } apb_phase_e;
endpackage : autoneg_pkg

// ===== rtl/sticky_flag.sv
// Sticky flag that an event sets and a clear request drops.
// Assumes set and clear are single-clock signals on i_clock.
`timescale 1ns/1ps
module sticky_flag (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_flag
);
  logic next_flag;

  // A set in the cycle of a clear wins, so no event is lost.
  always_comb begin
    next_flag = i_set | (o_flag & ~i_clear);
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_flag <= 1'b0;
    end else begin
      o_flag <= next_flag;
    end
  end

  a_set_wins_clear: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_set |=> o_flag) else $error("Flag lost an event.");
  a_flag_holds: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_flag && !i_clear |=> o_flag) else $error("Flag dropped without clear.");
endmodule : sticky_flag

// ===== rtl/autoneg_page_status_registers.sv
// Auto-negotiation partner ability, expansion, next page and digital control registers.
// Assumes an APB master on i_clock and an auto-negotiation engine on the same clock.
//
// How it works
// - Partner pause field at bits 11:10 is read-only, captured, resets to 00.
// - Partner T4, 100FD, 100HD, 10FD, 10HD bits are read-only, reset 0.
// - Partner selector field bits 4:0 is read-only and resets to 00001.
// - Parallel detection fault sets expansion bit 4, held until read.
// - Expansion bit 3 shows partner next-page capability, resets to 0.
// - Expansion bit 2 reports local next-page capability, reads 1.
// - A new page from the partner sets expansion bit 1, held until read.
// - Expansion bit 0 shows partner auto-negotiation ability, resets to 0.
// - Local next page bit 15 is writable, 1 means more pages follow.
// - Local message-page bit 13 (reset 1) and ack2 bit 12 (reset 0) are writable.
// - Local toggle bit 11 is read-only, inverts after each sent page, reset 0.
// - Local eleven-bit message field bits 10:0 is writable, resets to 1.
// - Partner acknowledge lands in read-only bit 14 of received next page.
// - Partner acknowledge-2 lands in read-only bit 12 of received next page.
// - Partner toggle lands in read-only bit 11 of received next page.
// - Partner next-page, message-page and message fields are read-only, reset 0.
// - Control bit 4 set turns the PLL off during energy-detect power-down.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module autoneg_page_status_registers (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [autoneg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire autoneg_pkg::base_word_s i_partner_base,
  input wire logic i_partner_base_valid,
  input wire autoneg_pkg::np_word_s i_partner_np,
  input wire logic i_partner_np_valid,
  input wire logic i_page_received,
  input wire logic i_parallel_fault,
  input wire logic i_partner_an_able,
  input wire logic i_np_sent,
  input wire logic i_energy_detect_power_down,
  output autoneg_pkg::np_word_s o_local_np,
  output logic [15:0] o_front_end_one,
  output logic o_pll_off,
  output logic o_irq
);
  // Index of a word-aligned address; unaligned or out-of-range yields no match.
  function automatic logic [5:0] reg_index(input logic [autoneg_pkg::ADDR_W-1:0] a);
    reg_index = a[autoneg_pkg::ADDR_W-1:2];
  endfunction : reg_index

  function automatic logic is_mapped(input logic [autoneg_pkg::ADDR_W-1:0] a);
    logic [5:0] i;
    i = reg_index(a);
    is_mapped = (a[1:0] == 2'b00) &&
      (i == autoneg_pkg::IDX_PARTNER_ABILITY || i == autoneg_pkg::IDX_EXPANSION ||
       i == autoneg_pkg::IDX_LOCAL_NP || i == autoneg_pkg::IDX_PARTNER_NP ||
       i == autoneg_pkg::IDX_DIGITAL_MISC || i == autoneg_pkg::IDX_FRONT_END_ONE ||
       i == autoneg_pkg::IDX_IRQ_STATUS || i == autoneg_pkg::IDX_IRQ_ENABLE ||
       i == autoneg_pkg::IDX_IRQ_CLEAR);
  endfunction : is_mapped

  // Bus phase machine: pready stays low for two access cycles, then a registered answer.
  autoneg_pkg::apb_phase_e phase;
  autoneg_pkg::apb_phase_e next_phase;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_pready;
  logic [5:0] idx;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic [15:0] wdata16;

  assign idx = reg_index(paddr);
  assign access_done = psel & penable & pready;
  assign wr_done = access_done & pwrite & ~pslverr;
  assign rd_done = access_done & ~pwrite & ~pslverr;

  // Byte lanes 0 and 1 carry the 16-bit register; a lane without strobe keeps its bits.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes = {{8{pstrb[1]}}, {8{pstrb[0]}}} & wmask;
    merge = (old & ~lanes) | (nw & lanes);
  endfunction : merge

  assign wdata16 = pwdata[15:0];

  // Register state.
  autoneg_pkg::base_word_s partner_ability;
  autoneg_pkg::base_word_s next_partner_ability;
  autoneg_pkg::np_word_s partner_np;
  autoneg_pkg::np_word_s next_partner_np;
  logic [15:0] local_np;
  logic [15:0] next_local_np;
  logic [15:0] digital_misc;
  logic [15:0] next_digital_misc;
  logic [15:0] front_end_one;
  logic [15:0] next_front_end_one;
  logic [autoneg_pkg::IRQ_N-1:0] irq_enable;
  logic [autoneg_pkg::IRQ_N-1:0] next_irq_enable;
  logic partner_an_able;
  logic next_partner_an_able;
  logic pll_off;
  logic next_pll_off;
  logic irq;
  logic next_irq;
  logic pd_fault_flag;
  logic page_rx_flag;
  logic [autoneg_pkg::IRQ_N-1:0] irq_status;
  logic [autoneg_pkg::IRQ_N-1:0] irq_event;
  logic [autoneg_pkg::IRQ_N-1:0] irq_clear;
  logic [15:0] expansion;
  logic exp_read;

  assign exp_read = rd_done && idx == autoneg_pkg::IDX_EXPANSION;

  // Latched-high expansion flags clear only on a read that returned them set.
  // An event that lands after the read data was taken stays latched for the next read.
  sticky_flag u_pd_fault (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_set(i_parallel_fault),
    .i_clear(exp_read & prdata[autoneg_pkg::EXP_PD_FAULT]),
    .o_flag(pd_fault_flag)
  );
  sticky_flag u_page_rx (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_set(i_page_received),
    .i_clear(exp_read & prdata[autoneg_pkg::EXP_PAGE_RX]),
    .o_flag(page_rx_flag)
  );

  assign irq_event[autoneg_pkg::IRQ_PAGE_RX] = i_page_received;
  assign irq_event[autoneg_pkg::IRQ_PD_FAULT] = i_parallel_fault;
  assign irq_event[autoneg_pkg::IRQ_LP_NP] = i_partner_np_valid;

  // Interrupt status bits, cleared by writing ones to the clear register.
  generate
    for (genvar g = 0; g < autoneg_pkg::IRQ_N; g++) begin : g_irq
      assign irq_clear[g] = wr_done && idx == autoneg_pkg::IDX_IRQ_CLEAR && pstrb[0] &&
                            pwdata[g];
      sticky_flag u_status (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_set(irq_event[g]),
        .i_clear(irq_clear[g]),
        .o_flag(irq_status[g])
      );
    end
  endgenerate

  always_comb begin
    expansion = 16'h0000;
    expansion[autoneg_pkg::EXP_PD_FAULT] = pd_fault_flag;
    expansion[autoneg_pkg::EXP_LP_NP_ABLE] = partner_ability.next_page;
    expansion[autoneg_pkg::EXP_NP_ABLE] = autoneg_pkg::LOCAL_NP_ABLE;
    expansion[autoneg_pkg::EXP_PAGE_RX] = page_rx_flag;
    expansion[autoneg_pkg::EXP_LP_AN_ABLE] = partner_an_able;
  end

  // Partner words are captured only from the negotiation engine, never from the bus.
  always_comb begin
    next_partner_ability = partner_ability;
    next_partner_np = partner_np;
    next_partner_an_able = i_partner_an_able;
    if (i_partner_base_valid) begin
      next_partner_ability = i_partner_base;
      next_partner_ability.reserved = 1'b0;
    end
    if (i_partner_np_valid) begin
      next_partner_np = i_partner_np;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      partner_ability <= autoneg_pkg::RST_PARTNER_ABILITY;
      partner_np <= autoneg_pkg::RST_PARTNER_NP;
      partner_an_able <= 1'b0;
    end else begin
      partner_ability <= next_partner_ability;
      partner_np <= next_partner_np;
      partner_an_able <= next_partner_an_able;
    end
  end

  // Writable registers and the local toggle.
  always_comb begin
    next_local_np = local_np;
    next_digital_misc = digital_misc;
    next_front_end_one = front_end_one;
    next_irq_enable = irq_enable;
    if (i_np_sent) begin
      next_local_np[autoneg_pkg::NP_TOGGLE] = ~local_np[autoneg_pkg::NP_TOGGLE];
    end
    if (wr_done) begin
      unique case (idx)
        autoneg_pkg::IDX_LOCAL_NP: begin
          next_local_np = merge(next_local_np, wdata16, autoneg_pkg::LOCAL_NP_WMASK);
        end
        autoneg_pkg::IDX_DIGITAL_MISC: begin
          next_digital_misc = merge(digital_misc, wdata16, 16'hffff);
        end
        autoneg_pkg::IDX_FRONT_END_ONE: begin
          next_front_end_one = merge(front_end_one, wdata16, 16'hffff);
        end
        autoneg_pkg::IDX_IRQ_ENABLE: begin
          if (pstrb[0]) begin
            next_irq_enable = pwdata[autoneg_pkg::IRQ_N-1:0];
          end
        end
        default: begin
          next_irq_enable = irq_enable;
        end
      endcase
    end
    next_pll_off = next_digital_misc[autoneg_pkg::DIG_PLL_OFF] & i_energy_detect_power_down;
    next_irq = |(irq_status & irq_enable);
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      local_np <= autoneg_pkg::RST_LOCAL_NP;
      digital_misc <= autoneg_pkg::RST_DIGITAL_MISC;
      front_end_one <= autoneg_pkg::RST_FRONT_END_ONE;
      irq_enable <= autoneg_pkg::RST_IRQ_ENABLE;
      pll_off <= 1'b0;
      irq <= 1'b0;
    end else begin
      local_np <= next_local_np;
      digital_misc <= next_digital_misc;
      front_end_one <= next_front_end_one;
      irq_enable <= next_irq_enable;
      pll_off <= next_pll_off;
      irq <= next_irq;
    end
  end

  assign o_local_np = local_np;
  assign o_front_end_one = front_end_one;
  assign o_pll_off = pll_off;
  assign o_irq = irq;

  // Bus answer: read data and error are registered in the wait cycle.
  always_comb begin
    next_phase = phase;
    next_prdata = prdata;
    next_pslverr = pslverr;
    unique case (phase)
      autoneg_pkg::PH_IDLE: begin
        if (psel && penable) begin
          next_phase = autoneg_pkg::PH_WAIT;
        end
      end
      autoneg_pkg::PH_WAIT: begin
        next_phase = autoneg_pkg::PH_DONE;
        next_pslverr = ~is_mapped(paddr);
        next_prdata = 32'h0000_0000;
        if (!pwrite && is_mapped(paddr)) begin
          unique case (idx)
            autoneg_pkg::IDX_PARTNER_ABILITY: next_prdata[15:0] = partner_ability;
            autoneg_pkg::IDX_EXPANSION: next_prdata[15:0] = expansion;
            autoneg_pkg::IDX_LOCAL_NP: next_prdata[15:0] = local_np;
            autoneg_pkg::IDX_PARTNER_NP: next_prdata[15:0] = partner_np;
            autoneg_pkg::IDX_DIGITAL_MISC: next_prdata[15:0] = digital_misc;
            autoneg_pkg::IDX_FRONT_END_ONE: next_prdata[15:0] = front_end_one;
            autoneg_pkg::IDX_IRQ_STATUS: next_prdata[autoneg_pkg::IRQ_N-1:0] = irq_status;
            autoneg_pkg::IDX_IRQ_ENABLE: next_prdata[autoneg_pkg::IRQ_N-1:0] = irq_enable;
            default: next_prdata = 32'h0000_0000;
          endcase
        end
      end
      autoneg_pkg::PH_DONE: begin
        next_phase = autoneg_pkg::PH_IDLE;
        next_pslverr = 1'b0;
      end
      default: begin
        next_phase = autoneg_pkg::PH_IDLE;
      end
    endcase
    next_pready = (next_phase == autoneg_pkg::PH_DONE);
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase <= autoneg_pkg::PH_IDLE;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      phase <= next_phase;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= next_pready;
    end
  end

  // Checks.
  sequence s_read_exp;
    rd_done && idx == autoneg_pkg::IDX_EXPANSION;
  endsequence

  // A fault followed by two cycles without an expansion read.
  sequence s_fault_unread;
    i_parallel_fault ##1 !(rd_done && idx == autoneg_pkg::IDX_EXPANSION) [*2];
  endsequence

  a_pause_capture: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_partner_base_valid |=> partner_ability.pause == $past(i_partner_base.pause))
    else $error("Pause field not captured.");
  a_ability_hold: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !i_partner_base_valid |=> $stable(partner_ability[9:5]))
    else $error("Ability bits changed without a page.");
  a_selector_capture: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_partner_base_valid |=> partner_ability.selector == $past(i_partner_base.selector))
    else $error("Selector not captured.");
  a_fault_latched: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    s_fault_unread |-> pd_fault_flag)
    else $error("Fault flag not held.");
  a_fault_read_clear: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    s_read_exp ##0 (prdata[autoneg_pkg::EXP_PD_FAULT] && !i_parallel_fault)
    |=> !pd_fault_flag) else $error("Fault flag not cleared by read.");
  a_page_rx_clear: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    s_read_exp ##0 (prdata[autoneg_pkg::EXP_PAGE_RX] && !i_page_received)
    |=> !page_rx_flag) else $error("Page received flag not cleared by read.");
  a_np_able_const: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    s_read_exp |-> prdata[autoneg_pkg::EXP_NP_ABLE] && prdata[31:5] == 27'h0000000)
    else $error("Expansion constant bits wrong.");
  a_page_rx_latched: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_page_received |=> page_rx_flag)
    else $error("Page received flag not set.");
  a_toggle_flip: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_np_sent |=> local_np[autoneg_pkg::NP_TOGGLE] != $past(local_np[autoneg_pkg::NP_TOGGLE]))
    else $error("Toggle did not flip.");
  a_np_ro_capture: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_partner_np_valid |=> partner_np == $past(i_partner_np))
    else $error("Partner next page not captured.");
  a_pll_off_follow: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    digital_misc[autoneg_pkg::DIG_PLL_OFF] && i_energy_detect_power_down && !wr_done
    |=> o_pll_off) else $error("PLL not turned off.");
  a_pll_on_kept: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !i_energy_detect_power_down |=> !o_pll_off)
    else $error("PLL off outside power-down.");
  a_ro_write_ignored: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    wr_done && idx == autoneg_pkg::IDX_PARTNER_NP && !i_partner_np_valid
    |=> $stable(partner_np)) else $error("Read-only register written.");
endmodule : autoneg_page_status_registers

// ===== dv/mgmt_master.sv
// Station management model: an APB master that the bench drives through apb_xfer.
// Assumes one clock shared with the register block and a slave that raises pready.
`timescale 1ns/1ps
module mgmt_master (
  input wire logic i_clock,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb
);
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
    o_pstrb = 4'h0;
  end

  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic err);
    rdata = 32'hffff_ffff;
    err = 1'bx;
    @(posedge i_clock);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= wr;
    o_paddr <= addr;
    o_pwdata <= wdata;
    o_pstrb <= 4'hf;
    @(posedge i_clock);
    o_penable <= 1'b1;
    // Only the bench watchdog ends a wait for the answer.
    do begin
      @(posedge i_clock);
    end while (i_pready !== 1'b1);
    rdata = i_prdata;
    err = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // Released address and write-data lines carry the inverse so stale values are never mistaken for live ones.
    o_paddr <= ~addr;
    o_pwdata <= ~wdata;
    o_pstrb <= 4'h0;
  endtask : apb_xfer
endmodule : mgmt_master

// ===== dv/autoneg_page_status_registers_bench.sv
// Self-checking bench for the auto-negotiation page and status registers.
// Assumes the management model drives APB and the bench plays the negotiation engine.
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module autoneg_page_status_registers_bench;
  logic i_clock;
  logic i_arst_n;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  autoneg_pkg::base_word_s partner_base;
  autoneg_pkg::np_word_s partner_np;
  autoneg_pkg::np_word_s local_np;
  logic [4:0] ev_pulse;
  logic an_able, energy_detect_power_down, pll_off, irq;
  logic [15:0] front_end_one;
  logic lp_np;
  int n_errors;
  int total_checks;

  autoneg_page_status_registers uut (.i_clock(i_clock), .i_arst_n(i_arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_partner_base(partner_base),
    .i_partner_base_valid(ev_pulse[3]), .i_partner_np(partner_np),
    .i_partner_np_valid(ev_pulse[4]), .i_page_received(ev_pulse[0]),
    .i_parallel_fault(ev_pulse[1]), .i_partner_an_able(an_able), .i_np_sent(ev_pulse[2]),
    .i_energy_detect_power_down(energy_detect_power_down), .o_local_np(local_np),
    .o_front_end_one(front_end_one), .o_pll_off(pll_off), .o_irq(irq));

  mgmt_master mgmt (.i_clock(i_clock), .i_pready(pready), .i_prdata(prdata),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb));

  task automatic wr(input logic [5:0] idx, input logic [15:0] v);
    logic [31:0] d;
    logic e;
    mgmt.apb_xfer(1'b1, {idx, 2'b00}, {16'h0, v}, d, e);
  endtask : wr

  task automatic rd_check(input string nm, input logic [5:0] idx, input logic [31:0] ex);
    logic [31:0] d;
    logic e;
    mgmt.apb_xfer(1'b0, {idx, 2'b00}, 32'h0, d, e);
    `CHECK(nm, ex, d)
  endtask : rd_check

  task automatic pulse(input logic [4:0] m);
    @(posedge i_clock);
    ev_pulse <= m;
    @(posedge i_clock);
    ev_pulse <= 5'h00;
    repeat (3) @(posedge i_clock);
  endtask : pulse

  task automatic t_reset();
    rd_check("ability", autoneg_pkg::IDX_PARTNER_ABILITY, 32'h0001);
    rd_check("expansion", autoneg_pkg::IDX_EXPANSION, 32'h0004);
    rd_check("local_np", autoneg_pkg::IDX_LOCAL_NP, 32'h2001);
    rd_check("partner_np", autoneg_pkg::IDX_PARTNER_NP, 32'h0000);
    rd_check("digital", autoneg_pkg::IDX_DIGITAL_MISC, 32'h0000);
    rd_check("front_end", autoneg_pkg::IDX_FRONT_END_ONE, 32'h0000);
    `CHECK("o_local_np", 16'h2001, local_np)
  endtask : t_reset

  task automatic t_partner_base();
    logic [15:0] w;
    for (int p = 0; p < 4; p++) begin
      w = 16'h5001 | (16'(p) << 10) | ((p % 2 == 1) ? 16'h8140 : 16'h02a0);
      partner_base <= w;
      pulse(5'h08);
      lp_np = w[15];
      rd_check("ability", autoneg_pkg::IDX_PARTNER_ABILITY, {16'h0, w & 16'hefff});
      rd_check("exp_lp_np", autoneg_pkg::IDX_EXPANSION, 32'h4 | {28'h0, lp_np, 3'h0});
    end
    wr(autoneg_pkg::IDX_PARTNER_ABILITY, 16'h0000);
    rd_check("ability_ro", autoneg_pkg::IDX_PARTNER_ABILITY, {16'h0, w & 16'hefff});
  endtask : t_partner_base

  task automatic t_latched();
    an_able <= 1'b1;
    pulse(5'h03);
    repeat (5) @(posedge i_clock);
    rd_check("exp_set", autoneg_pkg::IDX_EXPANSION, {28'h1, lp_np, 3'h7});
    rd_check("exp_clr", autoneg_pkg::IDX_EXPANSION, {28'h0, lp_np, 3'h5});
    an_able <= 1'b0;
    repeat (2) @(posedge i_clock);
    rd_check("exp_an", autoneg_pkg::IDX_EXPANSION, {28'h0, lp_np, 3'h4});
  endtask : t_latched

  task automatic t_local_np();
    wr(autoneg_pkg::IDX_LOCAL_NP, 16'hffff);
    rd_check("np_wr", autoneg_pkg::IDX_LOCAL_NP, 32'hb7ff);
    `CHECK("o_local_np", 16'hb7ff, local_np)
    pulse(5'h04);
    rd_check("np_tog1", autoneg_pkg::IDX_LOCAL_NP, 32'hbfff);
    wr(autoneg_pkg::IDX_LOCAL_NP, 16'h0000);
    rd_check("np_last", autoneg_pkg::IDX_LOCAL_NP, 32'h0800);
    pulse(5'h04);
    rd_check("np_tog0", autoneg_pkg::IDX_LOCAL_NP, 32'h0000);
  endtask : t_local_np

  task automatic t_partner_np();
    logic [15:0] pat [2];
    pat[0] = 16'h5a5a;
    pat[1] = 16'ha5a5;
    for (int i = 0; i < 2; i++) begin
      partner_np <= pat[i];
      pulse(5'h10);
      wr(autoneg_pkg::IDX_PARTNER_NP, ~pat[i]);
      rd_check("partner_np", autoneg_pkg::IDX_PARTNER_NP, {16'h0, pat[i]});
    end
  endtask : t_partner_np

  task automatic t_pll();
    for (int k = 0; k < 4; k++) begin
      wr(autoneg_pkg::IDX_DIGITAL_MISC, (k % 2 == 1) ? 16'h0010 : 16'h0000);
      energy_detect_power_down <= (k >= 2);
      repeat (3) @(posedge i_clock);
      `CHECK("pll_off", (k == 3), pll_off)
    end
    rd_check("digital", autoneg_pkg::IDX_DIGITAL_MISC, 32'h0010);
    energy_detect_power_down <= 1'b0;
    wr(autoneg_pkg::IDX_FRONT_END_ONE, 16'ha5c3);
    rd_check("front_end", autoneg_pkg::IDX_FRONT_END_ONE, 32'ha5c3);
    `CHECK("o_front_end", 16'ha5c3, front_end_one)
  endtask : t_pll

  task automatic t_irq();
    logic [4:0] evs [3];
    logic [31:0] d;
    logic e;
    evs[0] = 5'h01;
    evs[1] = 5'h02;
    evs[2] = 5'h10;
    for (int b = 0; b < 3; b++) begin
      wr(autoneg_pkg::IDX_IRQ_CLEAR, 16'h0007);
      wr(autoneg_pkg::IDX_IRQ_ENABLE, 16'h0000);
      pulse(evs[b]);
      `CHECK("irq_masked", 1'b0, irq)
      rd_check("irq_status", autoneg_pkg::IDX_IRQ_STATUS, 32'(1 << b));
      wr(autoneg_pkg::IDX_IRQ_ENABLE, 16'(1 << b));
      repeat (3) @(posedge i_clock);
      `CHECK("irq_on", 1'b1, irq)
      rd_check("irq_clr_rd", autoneg_pkg::IDX_IRQ_CLEAR, 32'h0);
      wr(autoneg_pkg::IDX_IRQ_CLEAR, 16'(1 << b));
      repeat (3) @(posedge i_clock);
      `CHECK("irq_off", 1'b0, irq)
      rd_check("irq_status0", autoneg_pkg::IDX_IRQ_STATUS, 32'h0);
    end
    mgmt.apb_xfer(1'b0, 8'hfc, 32'h0, d, e);
    `CHECK("unmapped_err", 1'b1, e)
    `CHECK("unmapped_data", 32'h0, d)
    mgmt.apb_xfer(1'b1, 8'h41, 32'h0, d, e);
    `CHECK("unaligned_err", 1'b1, e)
    rd_check("digital_kept", autoneg_pkg::IDX_DIGITAL_MISC, 32'h0010);
  endtask : t_irq

  task automatic give_verdict();
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  initial begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    give_verdict();
  end

  initial begin
    n_errors = 0;
    total_checks = 0;
    i_arst_n = 1'b0;
    partner_base = 16'h0;
    partner_np = 16'h0;
    ev_pulse = 5'h00;
    an_able = 1'b0;
    energy_detect_power_down = 1'b0;
    lp_np = 1'b0;
    repeat (5) @(posedge i_clock);
    i_arst_n <= 1'b1;
    t_reset();
    t_partner_base();
    t_latched();
    t_local_np();
    t_partner_np();
    t_pll();
    t_irq();
    give_verdict();
  end
endmodule : autoneg_page_status_registers_bench
